// file: src/slg_strap_gate.sv
// power-up strap latching, dual-purpose pin control and clock output gating
`timescale 1ns/1ps
`include "slg_regs.svh"

// Functional notes
// [RL1] Thirteen memory clock outputs copy the memory clock input.
// [RL2] Twelve gated memory clock outputs go low while halt input is low.
// [RL3] Free-running memory clock copy ignores the halt input.
// [RL4] Latched mode strap: 0 makes shared pin bus halt input, 1 reference output.
// [RL5] Five dual-purpose pins are inputs at power-up, clock outputs after capture.
// [RL6] Dual-purpose pins stay three-stated for the first 2 ms.
// [RL7] At period end levels are latched first, output buffers enabled afterwards.
// [RL8] The 2 ms period starts when the supply reaches 2.0 V.
// [RL9] Latched straps are kept until power is cycled.
// [RL10] Board ties each strap pin low for 0 or high for 1.
// [RL11] A shortened first CPU clock cycle at enable is allowed.
// [RL12] Spread spectrum is set by bits 1-0 of the first configuration byte.
// [RL13] With spread on, CPU and bus clocks are frequency-modulated.
// [RL14] Halt stops outputs low after a full cycle, restart with full cycle. The ioapic clock is gated by halt directly, even mid-cycle.
// [RL15] Bus halt sampled at fixed bus clock rise, applied from next cycle.
// [RL16] Latched frequency straps and mode go to frequency synthesis as a vector.
module slg_strap_gate #(
    parameter int SELECT_CYCLES = `SLG_SELECT_CYCLES,
    parameter int HALT_STAGES = `SLG_HALT_SYNC_STAGES,
    parameter int SPREAD_W = 8,
    parameter int SPREAD_DIV = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`SLG_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_supply_good,
    input wire logic [`SLG_DP_PINS-1:0] i_dp_pin,
    output logic [`SLG_DP_PINS-1:0] o_dp_pin,
    output logic [`SLG_DP_PINS-1:0] o_dp_oe,
    input wire logic i_shared_pin,
    output logic o_shared_pin,
    output logic o_shared_oe,
    input wire logic i_clk_halt_n,
    input wire logic i_memory_clock_in,
    output logic [`SLG_GATED_MEM-1:0] o_memory_clock_gated_out,
    output logic o_memory_clock_free_out,
    input wire logic i_cpu_clock_src,
    input wire logic i_bus_clock_src,
    input wire logic i_ref_clock_src,
    input wire logic i_usb_clock_src,
    input wire logic i_sio_clock_src,
    output logic o_cpu_clock_free,
    output logic o_cpu_clock_gated,
    output logic o_ioapic_clock,
    output logic [`SLG_GATED_BUS-1:0] o_bus_clock_gated,
    output slg_pkg::slg_freq_cfg_t o_freq_config,
    output logic o_config_valid,
    output logic o_spread_enable,
    output logic [SPREAD_W-1:0] o_spread_offset
);

    localparam int CNT_W = $clog2(SELECT_CYCLES + 1);

    // ==========================================
    // declarations
    slg_pkg::slg_state_t state;
    slg_pkg::slg_state_t next_state;
    logic [CNT_W-1:0] timer;
    logic [`SLG_DP_PINS-1:0] straps;
    logic straps_held;
    logic outputs_on;
    logic [`SLG_CTRL_SPREAD_W-1:0] spread_sel;
    logic bus_prev;
    logic bus_rise;
    logic bus_run;
    logic halt_level;
    logic [`SLG_GATED_BUS:0] bus_gated;
    logic cpu_gated;
    logic apb_setup;
    logic apb_access;
    logic hit;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    // ==========================================
    // helpers
    function automatic logic addr_known(input logic [`SLG_ADDR_W-1:0] a);
        addr_known = (a == `SLG_CTRL_OFFSET) || (a == `SLG_STATUS_OFFSET)
            || (a == `SLG_STRAP_OFFSET) || (a == `SLG_TIMER_OFFSET);
    endfunction

    function automatic logic [31:0] zext5(input logic [4:0] v);
        zext5 = {27'h0, v};
    endfunction

    // ==========================================
    // power-up sequence
    always_comb
    begin
        next_state = state;
        case (state)
            slg_pkg::ST_WAIT_POWER:
            begin
                if (i_supply_good)
                    next_state = slg_pkg::ST_SELECT; // RL8
            end
            slg_pkg::ST_SELECT:
            begin
                if (timer == CNT_W'(SELECT_CYCLES - 1))
                    next_state = slg_pkg::ST_LATCH; // RL6
            end
            slg_pkg::ST_LATCH:
            begin
                next_state = slg_pkg::ST_RUN; // RL7
            end
            slg_pkg::ST_RUN:
            begin
                next_state = slg_pkg::ST_RUN; // RL9
            end
            default:
            begin
                next_state = slg_pkg::ST_WAIT_POWER;
            end
        endcase
    end

    // power cycle is the only way back to the start
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            state <= slg_pkg::ST_WAIT_POWER;
        else
            state <= next_state;
    end

    // selection timer, running from the supply-good crossing
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            timer <= '0;
        else if (state == slg_pkg::ST_SELECT)
            timer <= timer + 1'b1; // RL8
    end

    // ==========================================
    // strap capture
    // capture happens one cycle before any buffer turns on, so the pins
    // still carry only the resistor level when sampled
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            straps <= '0;
            straps_held <= 1'b0;
        end
        else if (state == slg_pkg::ST_LATCH && !straps_held)
        begin
            straps <= i_dp_pin; // RL7 RL5
            straps_held <= 1'b1; // RL9
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            outputs_on <= 1'b0;
        else if (state == slg_pkg::ST_LATCH)
            outputs_on <= 1'b1; // RL7
    end

    // RL16
    assign o_freq_config.mode = straps[`SLG_DP_MODE];
    assign o_freq_config.freq_select = straps[`SLG_DP_FS3:`SLG_DP_FS0];
    assign o_config_valid = straps_held;

    // ==========================================
    // dual-purpose pins
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_dp_pin <= '0;
            o_dp_oe <= '0;
        end
        else if (outputs_on)
        begin
            o_dp_oe <= '1; // RL5
            o_dp_pin[`SLG_DP_FS0] <= i_usb_clock_src;
            o_dp_pin[`SLG_DP_FS1] <= i_sio_clock_src;
            o_dp_pin[`SLG_DP_FS2] <= i_ref_clock_src;
            o_dp_pin[`SLG_DP_FS3] <= bus_gated[`SLG_GATED_BUS];
            o_dp_pin[`SLG_DP_MODE] <= i_bus_clock_src;
        end
        else
        begin
            o_dp_oe <= '0; // RL6
            o_dp_pin <= '0;
        end
    end

    // ==========================================
    // shared pin: reference output or bus halt input
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_shared_pin <= 1'b0;
            o_shared_oe <= 1'b0;
        end
        else
        begin
            o_shared_oe <= outputs_on & straps[`SLG_DP_MODE]; // RL4
            o_shared_pin <= outputs_on & straps[`SLG_DP_MODE] & i_ref_clock_src;
        end
    end

    // ==========================================
    // bus clock halt
    assign bus_rise = i_bus_clock_src & ~bus_prev;
    // in reference mode the pin is an output, so no halt can be asserted
    assign halt_level = straps[`SLG_DP_MODE] ? 1'b1 : i_shared_pin; // RL4

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            bus_prev <= 1'b0;
        else
            bus_prev <= i_bus_clock_src;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            bus_run <= 1'b1;
        else if (bus_rise)
            bus_run <= halt_level; // RL15
    end

    // no extra delay: the gate waits for the low phase, i.e. the next cycle
    slg_clk_gate #(
        .WIDTH(`SLG_GATED_BUS + 1),
        .SYNC_STAGES(0)
    ) u_bus_gate (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_src(i_bus_clock_src),
        .i_run(bus_run & outputs_on), // RL15
        .o_clk(bus_gated)
    );

    assign o_bus_clock_gated = bus_gated[`SLG_GATED_BUS-1:0];

    // ==========================================
    // memory clock buffer
    // RL1 RL2 RL14
    slg_clk_gate #(
        .WIDTH(`SLG_GATED_MEM),
        .SYNC_STAGES(HALT_STAGES)
    ) u_mem_gate (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_src(i_memory_clock_in),
        .i_run(i_clk_halt_n),
        .o_clk(o_memory_clock_gated_out)
    );

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_memory_clock_free_out <= 1'b0;
        else
            o_memory_clock_free_out <= i_memory_clock_in; // RL3 RL1
    end

    // ==========================================
    // cpu and ioapic clocks
    // enable is not aligned to the source, so the first cycle may be short
    // RL14 RL11
    slg_clk_gate #(
        .WIDTH(1),
        .SYNC_STAGES(HALT_STAGES)
    ) u_cpu_gate (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_src(i_cpu_clock_src),
        .i_run(i_clk_halt_n & outputs_on),
        .o_clk(cpu_gated)
    );

    assign o_cpu_clock_gated = cpu_gated;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_cpu_clock_free <= 1'b0;
            o_ioapic_clock <= 1'b0;
        end
        else
        begin
            o_cpu_clock_free <= outputs_on & i_cpu_clock_src; // RL11
            o_ioapic_clock <= outputs_on & i_clk_halt_n & i_ref_clock_src;
        end
    end

    // ==========================================
    // spread spectrum
    assign o_spread_enable = |spread_sel; // RL12

    // RL13
    slg_spread_tri #(
        .OFS_W(SPREAD_W),
        .STEP_DIV(SPREAD_DIV)
    ) u_spread (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_enable(o_spread_enable & outputs_on),
        .i_depth(spread_sel),
        .o_offset(o_spread_offset)
    );

    // ==========================================
    // apb slave, zero wait states
    assign apb_setup = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable;
    assign o_pready = apb_access;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            spread_sel <= `SLG_CTRL_RESET;
        else if (apb_access && i_pwrite && i_paddr == `SLG_CTRL_OFFSET)
            spread_sel <= i_pwdata[`SLG_CTRL_SPREAD_LSB +: `SLG_CTRL_SPREAD_W]; // RL12
    end

    always_comb
    begin
        status_word = '0;
        status_word[`SLG_STAT_WAIT_BIT] = (state == slg_pkg::ST_WAIT_POWER);
        status_word[`SLG_STAT_SELECT_BIT] = (state == slg_pkg::ST_SELECT);
        status_word[`SLG_STAT_RUN_BIT] = straps_held;
        status_word[`SLG_STAT_HALT_BIT] = ~i_clk_halt_n;
        status_word[`SLG_STAT_BUS_RUN_BIT] = bus_run;
        status_word[`SLG_STAT_SPREAD_BIT] = o_spread_enable;
    end

    always_comb
    begin
        rd_word = '0;
        case (i_paddr)
            `SLG_CTRL_OFFSET: rd_word = {30'h0, spread_sel};
            `SLG_STATUS_OFFSET: rd_word = status_word;
            `SLG_STRAP_OFFSET: rd_word = zext5(straps);
            `SLG_TIMER_OFFSET: rd_word = 32'(timer);
            default: rd_word = '0;
        endcase
    end

    // read data and error are prepared in the setup cycle so both come from flops
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_prdata <= '0;
            hit <= 1'b0;
        end
        else if (apb_setup)
        begin
            o_prdata <= i_pwrite ? 32'h0 : rd_word;
            hit <= addr_known(i_paddr);
        end
    end

    assign o_pslverr = apb_access & ~hit;

endmodule

// file: src/slg_regs.svh
// register offsets, field positions, reset values and timing counts of the strap/gating block
`ifndef SLG_REGS_SVH
`define SLG_REGS_SVH

// ==========================================
// register map (byte addresses, one word each)
`define SLG_ADDR_W 12
`define SLG_CTRL_OFFSET 12'h000
`define SLG_STATUS_OFFSET 12'h004
`define SLG_STRAP_OFFSET 12'h008
`define SLG_TIMER_OFFSET 12'h00C

// ==========================================
// control register fields
`define SLG_CTRL_SPREAD_LSB 0
`define SLG_CTRL_SPREAD_W 2
`define SLG_CTRL_RESET 2'h0

// ==========================================
// status register fields
`define SLG_STAT_WAIT_BIT 0
`define SLG_STAT_SELECT_BIT 1
`define SLG_STAT_RUN_BIT 2
`define SLG_STAT_HALT_BIT 3
`define SLG_STAT_BUS_RUN_BIT 4
`define SLG_STAT_SPREAD_BIT 5

// ==========================================
// dual-purpose pin positions
`define SLG_DP_PINS 5
`define SLG_DP_FS0 0
`define SLG_DP_FS1 1
`define SLG_DP_FS2 2
`define SLG_DP_FS3 3
`define SLG_DP_MODE 4

// ==========================================
// timing
`define SLG_MCLK_HZ 25000000
`define SLG_SELECT_MS 2
`define SLG_SELECT_CYCLES ((`SLG_SELECT_MS * `SLG_MCLK_HZ) / 1000)
`define SLG_HALT_SYNC_STAGES 2
`define SLG_GATED_MEM 12
`define SLG_GATED_BUS 4

`endif

// file: src/slg_pkg.sv
// types shared by the strap/gating block
package slg_pkg;

    // ==========================================
    // power-up sequence states
    typedef enum logic [3:0] {
        ST_WAIT_POWER = 4'h1,
        ST_SELECT = 4'h2,
        ST_LATCH = 4'h4,
        ST_RUN = 4'h8
    } slg_state_t;

    // ==========================================
    // latched configuration handed to frequency synthesis
    typedef struct packed {
        logic mode;
        logic [3:0] freq_select;
    } slg_freq_cfg_t;

endpackage

// file: src/slg_clk_gate.sv
// glitch-free halt gate for a group of clock copies
`timescale 1ns/1ps
module slg_clk_gate #(
    parameter int WIDTH = 1,
    parameter int SYNC_STAGES = 2
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_src,
    input wire logic i_run,
    output logic [WIDTH-1:0] o_clk
);

    logic run_q;
    logic en;

    // ==========================================
    // run delay line
    generate
        if (SYNC_STAGES > 0)
        begin : g_dly
            logic [SYNC_STAGES-1:0] dly;
            always_ff @(posedge i_mclk)
            begin
                if (i_rst)
                    dly <= '0;
                else
                    dly <= {dly[SYNC_STAGES-2 >= 0 ? SYNC_STAGES-2 : 0:0], i_run};
            end
            assign run_q = dly[SYNC_STAGES-1];
        end
        else
        begin : g_nodly
            assign run_q = i_run;
        end
    endgenerate

    // ==========================================
    // enable moves only while the source is low, so a high phase is never cut
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            en <= 1'b0;
        else if (!i_src)
            en <= run_q;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_clk <= '0;
        else
            o_clk <= {WIDTH{i_src & en}};
    end

endmodule

// file: src/slg_spread_tri.sv
// triangular modulation profile for spread-spectrum clocking
`timescale 1ns/1ps
module slg_spread_tri #(
    parameter int OFS_W = 8,
    parameter int STEP_DIV = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [1:0] i_depth,
    output logic [OFS_W-1:0] o_offset
);

    localparam int DIV_W = $clog2(STEP_DIV + 1);

    logic [DIV_W-1:0] div;
    logic [OFS_W-1:0] level;
    logic [OFS_W-1:0] limit;
    logic down;

    // deeper setting widens the excursion by a factor of two per step
    always_comb
    begin
        limit = '1 >> (2'h3 - i_depth);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || !i_enable)
            div <= '0;
        else if (div == DIV_W'(STEP_DIV - 1))
            div <= '0;
        else
            div <= div + 1'b1;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || !i_enable)
        begin
            level <= '0;
            down <= 1'b0;
        end
        else if (div == DIV_W'(STEP_DIV - 1))
        begin
            if (!down && level >= limit)
                down <= 1'b1;
            else if (down && level == '0)
                down <= 1'b0;
            else if (down)
                level <= level - 1'b1;
            else
                level <= level + 1'b1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_offset <= '0;
        else
            o_offset <= i_enable ? level : '0;
    end

endmodule

// file: verif/slg_strap_gate_monitor.sv
// concurrent checks on the port behaviour of the strap/gating block
`timescale 1ns/1ps
`include "slg_regs.svh"
module slg_strap_gate_monitor #(
    parameter int SELECT_CYCLES = 20
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_supply_good,
    input wire logic i_clk_halt_n,
    input wire logic i_memory_clock_in,
    input wire logic i_shared_pin,
    input wire logic [`SLG_DP_PINS-1:0] o_dp_oe,
    input wire logic o_shared_oe,
    input wire logic [`SLG_GATED_MEM-1:0] o_memory_clock_gated_out,
    input wire logic o_memory_clock_free_out,
    input wire logic [`SLG_GATED_BUS-1:0] o_bus_clock_gated,
    input wire slg_pkg::slg_freq_cfg_t o_freq_config,
    input wire logic o_config_valid
);
    int sg_cnt;
    int bus_low_cnt;

    // ==========================================
    // helper counters
    // saturate so a long run never wraps
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            sg_cnt <= 0;
        else if (i_supply_good && sg_cnt < 100000)
            sg_cnt <= sg_cnt + 1;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst || !o_config_valid || o_freq_config.mode || i_shared_pin)
            bus_low_cnt <= 0;
        else if (bus_low_cnt < 1000)
            bus_low_cnt <= bus_low_cnt + 1;
    end

    // ==========================================
    // properties
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    property p_tri_until_latch;
        !o_config_valid |-> o_dp_oe == 5'h00;
    endproperty
    a_tri_until_latch: assert property (p_tri_until_latch)
        else $error("pins driven before straps latched");

    property p_latch_then_drive;
        $rose(o_dp_oe[0]) |-> $past(o_config_valid);
    endproperty
    a_latch_then_drive: assert property (p_latch_then_drive)
        else $error("buffer enabled before latch");

    property p_all_five;
        o_dp_oe inside {5'h00, 5'h1F};
    endproperty
    a_all_five: assert property (p_all_five)
        else $error("dual pins not switched together");

    property p_straps_held;
        o_config_valid && $past(o_config_valid) |-> $stable(o_freq_config);
    endproperty
    a_straps_held: assert property (p_straps_held)
        else $error("latched straps changed");

    property p_timer_start;
        $rose(o_config_valid) |-> sg_cnt >= SELECT_CYCLES;
    endproperty
    a_timer_start: assert property (p_timer_start)
        else $error("selection period cut short");

    property p_free_copy;
        !$past(i_rst) |-> o_memory_clock_free_out == $past(i_memory_clock_in);
    endproperty
    a_free_copy: assert property (p_free_copy)
        else $error("free memory copy wrong");

    property p_mem_halt;
        !i_clk_halt_n [*8] |-> o_memory_clock_gated_out == 12'h000;
    endproperty
    a_mem_halt: assert property (p_mem_halt)
        else $error("gated memory clocks not stopped");

    property p_mem_follow;
        i_clk_halt_n [*8] |-> o_memory_clock_gated_out == {12{$past(i_memory_clock_in)}};
    endproperty
    a_mem_follow: assert property (p_mem_follow)
        else $error("gated memory clocks not copying");

    property p_shared_role;
        o_shared_oe |-> o_config_valid && o_freq_config.mode;
    endproperty
    a_shared_role: assert property (p_shared_role)
        else $error("shared pin driven in halt role");

    property p_bus_halt;
        bus_low_cnt >= 20 |-> o_bus_clock_gated == 4'h0;
    endproperty
    a_bus_halt: assert property (p_bus_halt)
        else $error("bus clocks not stopped");
endmodule

bind slg_strap_gate slg_strap_gate_monitor #(.SELECT_CYCLES(SELECT_CYCLES)) mon_u (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_supply_good(i_supply_good),
    .i_clk_halt_n(i_clk_halt_n),
    .i_memory_clock_in(i_memory_clock_in),
    .i_shared_pin(i_shared_pin),
    .o_dp_oe(o_dp_oe),
    .o_shared_oe(o_shared_oe),
    .o_memory_clock_gated_out(o_memory_clock_gated_out),
    .o_memory_clock_free_out(o_memory_clock_free_out),
    .o_bus_clock_gated(o_bus_clock_gated),
    .o_freq_config(o_freq_config),
    .o_config_valid(o_config_valid)
);

// file: verif/slg_board.sv
// board model: strap resistors, chipset halt request and clock sources
`timescale 1ns/1ps
module slg_board (
    input wire logic i_mclk,
    input wire logic [4:0] i_strap,
    input wire logic i_halt_req_n,
    input wire logic [4:0] i_dp_drive,
    input wire logic [4:0] i_dp_oe,
    input wire logic i_shared_drive,
    input wire logic i_shared_oe,
    output logic [4:0] o_dp_level,
    output logic o_shared_level,
    output logic [5:0] o_src
);
    logic [3:0] phase = 4'h0;

    always_ff @(posedge i_mclk)
        phase <= phase + 4'h1;

    // strap resistor wins only while the pin is released
    assign o_dp_level = (i_dp_oe & i_dp_drive) | (~i_dp_oe & i_strap);
    assign o_shared_level = i_shared_oe ? i_shared_drive : i_halt_req_n;
    // {sio, usb, ref, bus, cpu, mem}
    assign o_src = {phase[3], phase[0], phase[1], phase[2], phase[0], phase[1]};
endmodule

// file: verif/slg_strap_gate_tb.sv
// self-checking testbench of the strap/gating block
`timescale 1ns/1ps
`include "slg_regs.svh"
`define CHK(got, exp, msg) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("BAD t=%0t %s", $time, msg); \
        end \
    end
module slg_strap_gate_tb;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic supply_good = 1'b0;
    logic halt_n = 1'b1;
    logic halt_req_n = 1'b1;
    logic [4:0] strap = 5'h00;
    wire [31:0] prdata;
    wire pready, pslverr, shared_drive, shared_oe, shared_lvl, mem_free, cpu_free, cpu_gated;
    wire ioapic, cfg_valid, spread_en;
    wire [4:0] dp_drive, dp_oe, dp_lvl;
    wire [5:0] src;
    wire [11:0] mem_gated;
    wire [3:0] bus_gated;
    wire [7:0] spread_ofs;
    slg_pkg::slg_freq_cfg_t freq_cfg;
    integer seed = 32'hE4DF;
    int errors = 0;
    int num_checks = 0;
    logic [31:0] rd, d;
    logic err, or_mem, or_bus, or_free, or_cpu, ofs_moved;
    logic [4:0] s;
    logic [7:0] ofs0;

    always #20 i_mclk = ~i_mclk;

    slg_strap_gate #(.SELECT_CYCLES(20)) dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_supply_good(supply_good),
        .i_dp_pin(dp_lvl), .o_dp_pin(dp_drive), .o_dp_oe(dp_oe), .i_shared_pin(shared_lvl),
        .o_shared_pin(shared_drive), .o_shared_oe(shared_oe), .i_clk_halt_n(halt_n),
        .i_memory_clock_in(src[0]), .o_memory_clock_gated_out(mem_gated),
        .o_memory_clock_free_out(mem_free), .i_cpu_clock_src(src[1]),
        .i_bus_clock_src(src[2]), .i_ref_clock_src(src[3]), .i_usb_clock_src(src[4]),
        .i_sio_clock_src(src[5]), .o_cpu_clock_free(cpu_free), .o_cpu_clock_gated(cpu_gated),
        .o_ioapic_clock(ioapic), .o_bus_clock_gated(bus_gated), .o_freq_config(freq_cfg),
        .o_config_valid(cfg_valid), .o_spread_enable(spread_en), .o_spread_offset(spread_ofs)
    );

    slg_board board_u (
        .i_mclk(i_mclk), .i_strap(strap), .i_halt_req_n(halt_req_n), .i_dp_drive(dp_drive),
        .i_dp_oe(dp_oe), .i_shared_drive(shared_drive), .i_shared_oe(shared_oe),
        .o_dp_level(dp_lvl), .o_shared_level(shared_lvl), .o_src(src)
    );

    // ==========================================
    // tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_for(input int n);
        if (n >= 200)
        begin
            errors++;
            $display("BAD t=%0t wait ran out", $time);
            close_out();
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        wait_for(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // halt effects take a few cycles, so only a settled window is judged
    task automatic observe(input int n);
        or_mem = 1'b0;
        or_bus = 1'b0;
        or_free = 1'b0;
        or_cpu = 1'b0;
        ofs_moved = 1'b0;
        ofs0 = spread_ofs;
        repeat (n)
        begin
            @(posedge i_mclk);
            or_mem |= |mem_gated;
            or_bus |= |bus_gated | dp_drive[3];
            or_free |= mem_free & cpu_free;
            or_cpu |= cpu_gated | ioapic;
            ofs_moved |= (spread_ofs !== ofs0);
        end
    endtask

    task automatic power_up(input logic [4:0] sv);
        int n;
        strap <= sv;
        supply_good <= 1'b0;
        i_rst <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (30) @(posedge i_mclk);
        `CHK(cfg_valid, 1'b0, "latched without supply")
        supply_good <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (cfg_valid !== 1'b1 && n < 200);
        wait_for(n);
        `CHK(freq_cfg, sv, "strap vector")
        repeat (3) @(posedge i_mclk);
        `CHK(dp_oe, 5'h1F, "pins not driving")
        `CHK(shared_oe, sv[4], "shared pin role")
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        for (int m = 0; m < 2; m++)
        begin
            s = 5'($random(seed));
            s[4] = m[0];
            power_up(s);
            strap <= ~s;
            supply_good <= 1'b0;
            repeat (40) @(posedge i_mclk);
            `CHK(freq_cfg, s, "straps recaptured")
            apb(1'b0, `SLG_STRAP_OFFSET, 32'h0);
            `CHK(rd[4:0], s, "strap readback")
            $display("power-up test done, mode %0d", m);
            for (int k = 0; k < 4; k++)
            begin
                d = $random(seed);
                d[1:0] = 2'(k);
                apb(1'b1, `SLG_CTRL_OFFSET, d);
                apb(1'b0, `SLG_CTRL_OFFSET, 32'h0);
                `CHK(rd, {30'h0, d[1:0]}, "spread select readback")
                `CHK(spread_en, |d[1:0], "spread enable")
                apb(1'b0, `SLG_STATUS_OFFSET, 32'h0);
                `CHK(rd[`SLG_STAT_SPREAD_BIT], |d[1:0], "spread status")
            end
            observe(40);
            `CHK(ofs_moved, 1'b1, "no modulation with spread on")
            apb(1'b0, 12'h010, 32'h0);
            `CHK(err, 1'b1, "unmapped read accepted")
            $display("register test done");
            halt_n <= 1'b0;
            repeat (8) @(posedge i_mclk);
            observe(16);
            `CHK(or_mem, 1'b0, "memory clocks ran in halt")
            `CHK(or_free, 1'b1, "free copy stopped")
            `CHK(or_cpu, 1'b0, "cpu clock ran in halt")
            halt_n <= 1'b1;
            repeat (8) @(posedge i_mclk);
            observe(16);
            `CHK(or_mem, 1'b1, "memory clocks idle")
            `CHK(or_cpu, 1'b1, "cpu clock not restarted")
            halt_req_n <= 1'b0;
            repeat (24) @(posedge i_mclk);
            observe(16);
            `CHK(or_bus, s[4], "bus halt in wrong mode")
            halt_req_n <= 1'b1;
            repeat (24) @(posedge i_mclk);
            observe(16);
            `CHK(or_bus, 1'b1, "bus clocks idle")
            $display("halt test done");
        end
        close_out();
    end
endmodule
